// file: hdl/pscec_pkg.sv
package pscec_pkg;
  localparam int          REG_ADDR_W       = 5;
  localparam int          REG_DATA_W       = 16;
  localparam logic [4:0]  ADDR_SPECIAL_CTL = 5'h11;
  localparam logic [4:0]  ADDR_RESERVED18  = 5'h12;
  localparam logic [4:0]  ADDR_FALSE_CAR   = 5'h13;
  localparam logic [4:0]  ADDR_DISCONNECT  = 5'h14;
  localparam logic [4:0]  ADDR_ERR_FRAME   = 5'h15;
  localparam logic [4:0]  ADDR_SYM_ERR     = 5'h16;
  localparam logic [4:0]  ADDR_PREM_EOF    = 5'h17;
  localparam logic [4:0]  ADDR_TEN_EOF     = 5'h18;
  localparam logic [4:0]  ADDR_JABBER      = 5'h19;
  localparam int          NUM_COUNTERS     = 7;
  localparam logic [15:0] SPECIAL_CTL_RST  = 16'h0000;
  localparam logic [15:0] COUNTER_RST      = 16'h0000;
  localparam logic [15:0] PREM_EOF_RST     = 16'h0001;
  localparam int          SYM_RUN_LEN      = 6;
  localparam int          BIT_SCR_BYPASS   = 15;
  localparam int          BIT_BYP_4B5B     = 14;
  localparam int          BIT_FORCE_H      = 13;
  localparam int          BIT_FORCE_34     = 12;
  localparam int          BIT_VALID_LINK   = 11;
  localparam int          BIT_SYM_ERR_EN   = 10;
  localparam int          BIT_CRS_DIS      = 9;
  localparam int          BIT_DPD_DIS      = 8;
  localparam int          BIT_AN_LOOP      = 7;
  localparam int          BIT_MDI_TRI      = 6;
  localparam int          BIT_FORCE_POL    = 5;
  localparam int          BIT_APOL_DIS     = 4;
  localparam int          BIT_SQ_DIS       = 3;
  localparam int          BIT_EXT_SQ       = 2;
  localparam int          BIT_LINK_DIS     = 1;
  localparam int          BIT_JAB_DIS      = 0;
endpackage

// file: hdl/pscec_count_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pscec_count_if #(parameter int W = 16);
  logic         inc;
  logic         clr;
  logic [W-1:0] value;
  modport owner (input inc, input clr, output value);
  modport user  (output inc, output clr, input value);
endinterface
`default_nettype wire

// file: hdl/pscec_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pscec_sat_counter
  import pscec_pkg::*;
#(
  parameter int          W         = 16,
  parameter logic [15:0] RST_VALUE = 16'h0000
) (
  input  wire logic   clk,  // system clock
  input  wire logic   rst,  // async reset, active high
  pscec_count_if.owner cnt  // increment, clear and value
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt.value <= RST_VALUE[W-1:0];
    end else if (cnt.clr) begin
      // event beside a clearing read counts after the clear
      cnt.value <= cnt.inc ? {{(W-1){1'b0}}, 1'b1} : '0;
    end else if (cnt.inc && (cnt.value != {W{1'b1}})) begin
      cnt.value <= cnt.value + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// file: hdl/pscec_top.sv
// Functional notes
// - bit 15 set routes tx and rx symbols around the scrambler
// - bit 14 set bypasses 4B/5B coding
// - bit 13 forces H pattern, bit 12 forces 34 pattern
// - bit 11 set forces the 100BASE-TX link valid
// - bit 10 set enables the symbol error output
// - bit 9 set disables 100 Mbps receive carrier sense
// - bit 8 set disables dynamic power-down
// - bit 7 set puts auto-negotiation in loopback
// - bit 6 set tri-states the line transmit drivers
// - bit 5 forces reversed polarity, bit 4 disables auto polarity
// - bit 3 set disables the 10BASE-T squelch test
// - bit 2 set enables 10BASE-T extended squelch
// - bit 1 set disables link integrity, link disabled
// - 16-bit false carrier counter, clear on read
// - 16-bit disconnect counter, saturating, clear on read
// - error frame counter adds at most one per errored frame
// - symbol error counter counts each run of six bad symbols once
// - premature end of frame counter, saturating, resets to one
// - 10BASE-T end of frame counter, saturating, clear on read
// - jabber detect counter, saturating, clear on read
// - register after special control reads all zero
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pscec_top
  import pscec_pkg::*;
(
  input  wire logic                  clk,            // 200 MHz clock
  input  wire logic                  rst,            // async reset, active high
  input  wire logic [REG_ADDR_W-1:0] regAddr,        // register address
  input  wire logic [REG_DATA_W-1:0] regWrData,      // write data
  input  wire logic                  regWr,          // write strobe
  input  wire logic                  regRd,          // read strobe
  output logic      [REG_DATA_W-1:0] regRdData,      // read data, cycle after strobe
  input  wire logic                  evFalseCarrier, // false carrier event pulse
  input  wire logic                  evDisconnect,   // disconnect event pulse
  input  wire logic                  rxFrameActive,  // receive frame in progress
  input  wire logic                  rxError,        // any receive error pulse
  input  wire logic                  rxSymbolBad,    // bad symbol pulse
  input  wire logic                  evPrematureEof, // premature end of frame pulse
  input  wire logic                  evTenEof,       // 10BASE-T end of frame pulse
  input  wire logic                  evJabber,       // jabber detect pulse
  output logic                       scramblerBypass,  // skip scrambler
  output logic                       codingBypass,     // skip 4B/5B
  output logic                       forceHPattern,    // send H pattern
  output logic                       force34Pattern,   // send 34 pattern
  output logic                       forceLinkValid,   // treat link as valid
  output logic                       symbolErrOutEn,   // symbol error output enable
  output logic                       carrierSenseOff,  // carrier sense disabled
  output logic                       dynPowerDownOff,  // dynamic power-down disabled
  output logic                       anLoopback,       // auto-negotiation loopback
  output logic                       lineDriverTri,    // line drivers high-impedance
  output logic                       forceReversePol,  // reversed polarity
  output logic                       autoPolarityOff,  // auto polarity disabled
  output logic                       squelchTestOff,   // squelch test disabled
  output logic                       extSquelchOn,     // extended squelch enabled
  output logic                       linkIntegrityOff, // link integrity disabled
  output logic                       jabberOff         // jabber function disabled
);
  logic [REG_DATA_W-1:0] specialCtl;
  logic                  rxFrameD;
  logic                  frameErrSeen;
  logic [2:0]            badRun;
  logic                  errFrameInc;
  logic                  symErrInc;

  pscec_count_if #(.W(REG_DATA_W)) cnt [NUM_COUNTERS] ();

  function automatic logic [2:0] cnt_index(input logic [REG_ADDR_W-1:0] a);
    cnt_index = 3'(a - ADDR_FALSE_CAR);
  endfunction

  function automatic logic is_counter(input logic [REG_ADDR_W-1:0] a);
    is_counter = (a >= ADDR_FALSE_CAR) && (a <= ADDR_JABBER);
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      specialCtl <= SPECIAL_CTL_RST;
    end else if (regWr && (regAddr == ADDR_SPECIAL_CTL)) begin
      specialCtl <= regWrData;
    end
  end

  assign scramblerBypass  = specialCtl[BIT_SCR_BYPASS];
  assign codingBypass     = specialCtl[BIT_BYP_4B5B];
  assign forceHPattern    = specialCtl[BIT_FORCE_H];
  assign force34Pattern   = specialCtl[BIT_FORCE_34];
  assign forceLinkValid   = specialCtl[BIT_VALID_LINK];
  assign symbolErrOutEn   = specialCtl[BIT_SYM_ERR_EN];
  assign carrierSenseOff  = specialCtl[BIT_CRS_DIS];
  assign dynPowerDownOff  = specialCtl[BIT_DPD_DIS];
  assign anLoopback       = specialCtl[BIT_AN_LOOP];
  assign lineDriverTri    = specialCtl[BIT_MDI_TRI];
  assign forceReversePol  = specialCtl[BIT_FORCE_POL];
  assign autoPolarityOff  = specialCtl[BIT_APOL_DIS];
  assign squelchTestOff   = specialCtl[BIT_SQ_DIS];
  assign extSquelchOn     = specialCtl[BIT_EXT_SQ];
  assign linkIntegrityOff = specialCtl[BIT_LINK_DIS];
  assign jabberOff        = specialCtl[BIT_JAB_DIS];

  // one count per errored frame; flag rearms at frame start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxFrameD     <= 1'b0;
      frameErrSeen <= 1'b0;
    end else begin
      rxFrameD <= rxFrameActive;
      if (rxFrameActive && !rxFrameD) begin
        frameErrSeen <= rxError;
      end else if (rxError) begin
        frameErrSeen <= 1'b1;
      end
    end
  end
  assign errFrameInc = rxError && (!frameErrSeen || (rxFrameActive && !rxFrameD));

  // counts the first bad symbol of each run of six
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      badRun <= '0;
    end else if (rxFrameActive && !rxFrameD) begin
      badRun <= rxSymbolBad ? 3'd1 : 3'd0;
    end else if (rxSymbolBad) begin
      badRun <= (badRun == 3'(SYM_RUN_LEN - 1)) ? 3'd0 : badRun + 3'd1;
    end
  end
  assign symErrInc = rxSymbolBad && ((badRun == 3'd0) || (rxFrameActive && !rxFrameD));

  assign cnt[0].inc = evFalseCarrier;
  assign cnt[1].inc = evDisconnect;
  assign cnt[2].inc = errFrameInc;
  assign cnt[3].inc = symErrInc;
  assign cnt[4].inc = evPrematureEof;
  assign cnt[5].inc = evTenEof;
  assign cnt[6].inc = evJabber;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      assign cnt[gi].clr = regRd && is_counter(regAddr) && (cnt_index(regAddr) == 3'(gi));
      pscec_sat_counter #(
        .W        (REG_DATA_W),
        .RST_VALUE((gi == 4) ? PREM_EOF_RST : COUNTER_RST)
      ) u_cnt (
        .clk(clk),
        .rst(rst),
        .cnt(cnt[gi])
      );
    end
  endgenerate

  logic [REG_DATA_W-1:0] cntValues [NUM_COUNTERS];
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_val
      assign cntValues[gi] = cnt[gi].value;
    end
  endgenerate

  // read data captured before the clear takes effect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      if (regAddr == ADDR_SPECIAL_CTL) begin
        regRdData <= specialCtl;
      end else if (is_counter(regAddr)) begin
        regRdData <= cntValues[cnt_index(regAddr)];
      end else begin
        regRdData <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/pscec_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pscec_top_asserts
  import pscec_pkg::*;
(
  input wire logic                  clk, rst, regWr, regRd,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWrData, regRdData,
  input wire logic                  evFalseCarrier, evDisconnect, evPrematureEof, evJabber,
  input wire logic                  scramblerBypass, codingBypass, forceHPattern, force34Pattern,
  input wire logic                  forceLinkValid, symbolErrOutEn, carrierSenseOff,
  input wire logic                  dynPowerDownOff, anLoopback, lineDriverTri, forceReversePol,
  input wire logic                  autoPolarityOff, squelchTestOff, extSquelchOn,
  input wire logic                  linkIntegrityOff, jabberOff
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [15:0] ctl = {scramblerBypass, codingBypass, forceHPattern, force34Pattern,
    forceLinkValid, symbolErrOutEn, carrierSenseOff, dynPowerDownOff, anLoopback, lineDriverTri,
    forceReversePol, autoPolarityOff, squelchTestOff, extSquelchOn, linkIntegrityOff, jabberOff};
  wire logic ctlWr = regWr && regAddr == ADDR_SPECIAL_CTL;
  wire logic ctlRd = regRd && regAddr == ADDR_SPECIAL_CTL;
  // two reads of one counter in a row: the second sees only the first read's event
  sequence twoRd(a);
    regRd && regAddr == a ##1 regRd && regAddr == a;
  endsequence
  a_ctl_lands: assert property (ctlWr |=> ctl == $past(regWrData))
    else $error("control outputs differ from written word");
  a_ctl_holds: assert property (!ctlWr |=> $stable(ctl))
    else $error("control outputs moved without a write");
  a_ctl_readback: assert property (ctlRd |=> regRdData == $past(ctl))
    else $error("control read returned wrong word");
  a_rsvd_zero: assert property (regRd && regAddr == ADDR_RESERVED18 |=> !(|regRdData))
    else $error("reserved register read nonzero");
  a_fc_clear: assert property (twoRd(ADDR_FALSE_CAR) |=>
    regRdData == {15'h0000, $past(evFalseCarrier, 2)}) else $error("false carrier not cleared");
  a_disc_clear: assert property (twoRd(ADDR_DISCONNECT) |=>
    regRdData == {15'h0000, $past(evDisconnect, 2)}) else $error("disconnect not cleared");
  a_peof_clear: assert property (twoRd(ADDR_PREM_EOF) |=>
    regRdData == {15'h0000, $past(evPrematureEof, 2)}) else $error("early end not cleared");
  a_jab_clear: assert property (twoRd(ADDR_JABBER) |=>
    regRdData == {15'h0000, $past(evJabber, 2)}) else $error("jabber count not cleared");
  c_ctl_write: cover property (ctlWr);
  c_two_reads: cover property (twoRd(ADDR_DISCONNECT));
  c_rsvd_read: cover property (regRd && regAddr == ADDR_RESERVED18);
endmodule
bind pscec_top pscec_top_asserts chk_u (.*);
`default_nettype wire

// file: tb/pscec_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module pscec_mgmt_model
  import pscec_pkg::*;
(
  input  wire logic                  clk,       // system clock
  output logic      [REG_ADDR_W-1:0] regAddr,   // register address
  output logic      [REG_DATA_W-1:0] regWrData, // write data
  output logic                       regWr,     // write strobe
  output logic                       regRd      // read strobe
);
  initial {regAddr, regWrData, regWr, regRd} = '0;
  // one bus cycle: each signal set once, held through the edge that takes it
  task automatic op(input logic w, r, input logic [4:0] a, input logic [15:0] d);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/pscec_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pscec_top_tb;
  import pscec_pkg::*;
  logic clk, rst, rxFrameActive, rxError, rxSymbolBad, regWr, regRd, rdHit, wrHit;
  logic [4:0] ev, regAddr;
  logic [15:0] regWrData, regRdData, ctlExp, d;
  logic scramblerBypass, codingBypass, forceHPattern, force34Pattern, forceLinkValid;
  logic symbolErrOutEn, carrierSenseOff, dynPowerDownOff, anLoopback, lineDriverTri;
  logic forceReversePol, autoPolarityOff, squelchTestOff, extSquelchOn, linkIntegrityOff;
  logic jabberOff;
  wire logic evFalseCarrier = ev[0], evDisconnect = ev[1], evPrematureEof = ev[2];
  wire logic evTenEof = ev[3], evJabber = ev[4];
  wire logic [15:0] ctl = {scramblerBypass, codingBypass, forceHPattern, force34Pattern,
    forceLinkValid, symbolErrOutEn, carrierSenseOff, dynPowerDownOff, anLoopback, lineDriverTri,
    forceReversePol, autoPolarityOff, squelchTestOff, extSquelchOn, linkIntegrityOff, jabberOff};
  logic [4:0] cnt [5] = '{ADDR_FALSE_CAR, ADDR_DISCONNECT, ADDR_PREM_EOF, ADDR_TEN_EOF, ADDR_JABBER};
  logic [15:0] rdQ[$], ctlQ[$];
  int err_total = 0, checked = 0, n;
  pscec_top dut_u (.*);
  pscec_mgmt_model mgmt_u (.*);
  task automatic cmp(input string s, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cmp_ctl(input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED control outputs expected %h seen %h", e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    if (a == ADDR_SPECIAL_CTL) ctlExp = v;
    ctlQ.push_back(ctlExp);
    mgmt_u.op(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rdQ.push_back(e);
    mgmt_u.op(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle();
    mgmt_u.op(1'b0, 1'b0, 5'h00, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // results land in the cycle after the strobe
  always @(posedge clk) begin
    rdHit = regRd;
    wrHit = regWr;
    #1;
    if (rdHit) cmp("read data", rdQ.pop_front(), regRdData);
    if (wrHit) cmp_ctl(ctlQ.pop_front(), ctl);
  end
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    {ev, rxFrameActive, rxError, rxSymbolBad} = 8'h00;
    rst = 1'b1;
    ctlExp = 16'h0000;
    void'($urandom(32'h782b64fa));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 16; a <= 26; a++) rd(5'(a), {15'h0000, 5'(a) == ADDR_PREM_EOF});
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_SPECIAL_CTL, 16'h0001 << i);
      rd(ADDR_SPECIAL_CTL, 16'h0001 << i);
    end
    d = 16'($urandom);
    wr(ADDR_SPECIAL_CTL, d);
    wr(ADDR_RESERVED18, ~d);
    rd(ADDR_RESERVED18, 16'h0000);
    rd(ADDR_SPECIAL_CTL, d);
    $display("control register done");
    for (int k = 0; k < 5; k++) begin
      n = 1 + $urandom % 40;
      ev <= 5'h01 << k;
      idle();
      repeat (n - 1) @(posedge clk);
      rd(cnt[k], 16'(n));
      ev <= 5'h00;
      rd(cnt[k], 16'h0001);
    end
    ev <= 5'h02;
    idle();
    repeat (65536) @(posedge clk);
    ev <= 5'h00;
    rd(ADDR_DISCONNECT, 16'hffff);
    $display("event counters done");
    repeat (2) begin
      rxFrameActive <= 1'b1;
      idle();
      {rxError, rxSymbolBad} <= 2'b11;
      repeat (13) @(posedge clk);
      {rxError, rxSymbolBad, rxFrameActive} <= 3'b000;
      @(posedge clk);
    end
    rd(ADDR_ERR_FRAME, 16'h0002);
    rd(ADDR_SYM_ERR, 16'h0006);
    idle();
    $display("frame counters done");
    print_verdict();
  end
endmodule
`default_nettype wire
